// ### hw/wkr_wakeup_top.sv
// Wait and stop exit control: vector choice, stop recovery, low supply reset
//
// Function
// - Reset pin low resets, fetches reset vector
// - IRQ falling edge wakes, uses IRQ vector
// - Break in emulation wakes, uses break vector
// - Watchdog expiry in wait resets controller
// - Clock generator request ends wait, own vector
// - Keypad request ends wait, keypad vector
// - Timer one requests end wait, own vectors
// - Timer two requests end wait, per-source vectors
// - Serial requests end wait, separate vectors
// - Converter done ends wait, converter vector
// - Timebase rollover wakes wait or stop
// - Keypad edges by polarity wake stop
// - Only listed sources end stop, restart clocks
// - Stop recovery holds clocks 4096 crystal cycles
// - Short recovery select gives 32 cycles
// - Monitor enabled after reset unless powered off
// - Reset below falling trip unless reset-off
// - Monitor runs in stop only if enabled
// - Trip range high when set, low after power-on
// - Low supply reset held until above rising
// - High range below rising trip resets at once
// - Flag sets/clears/holds with trip levels, no interrupt
`timescale 1ns/10ps
module wkr_wakeup_top #(
	parameter int KEYS = wkr_pkg::KEY_PINS,
	parameter logic [12:0] FULL_COUNT = wkr_pkg::RECOV_FULL,
	parameter logic [12:0] SHORT_COUNT = wkr_pkg::RECOV_SHORT
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic power_on_reset,
	input wire logic crystal_ref_clock,
	input wire logic ext_reset_n,
	input wire logic irq_pin_n,
	input wire logic [KEYS-1:0] keypad_pins,
	input wire logic [KEYS-1:0] keypad_edge_polarity,
	input wire logic [KEYS-1:0] keypad_enable,
	input wire logic emulation_mode,
	input wire logic break_req,
	input wire logic watchdog_expire,
	input wire wkr_pkg::wkr_req_s periph_req,
	input wire logic osc_keep_in_stop,
	input wire wkr_pkg::wkr_cfg_s config_word_one,
	input wire logic wait_enter,
	input wire logic stop_enter,
	input wire logic below_falling_trip,
	input wire logic above_rising_trip,
	output logic trip_range_high,
	output logic supply_low_flag,
	output logic system_reset,
	output logic reset_pin_drive_n,
	output logic clocks_run,
	output logic vector_valid,
	output logic [15:0] vector_addr,
	output logic in_wait,
	output logic in_stop
);
	wkr_pkg::wkr_state_e state_reg;
	wkr_pkg::wkr_state_e state_next;
	wkr_pkg::wkr_req_s req;
	logic stop_mode_reg;
	logic irq_pin_reg;
	logic [KEYS-1:0] key_reg;
	logic [KEYS-1:0] key_edge;
	logic irq_edge;
	logic key_any;
	logic hit;
	logic [15:0] sel_vec;
	logic lv_reset;
	logic hard_reset;
	logic trip_high_reg;
	logic xclk_reg;
	logic xclk_rise;
	logic [12:0] recov_cnt_reg;
	logic recov_done;
	logic [15:0] vec_hold_reg;
	logic vec_pend_reg;
	logic edge_arm_reg;
	logic range_raised;
	logic pin_reset;
	logic dog_reset;
	logic wake_take;

	// Edge capture of the interrupt pins; inputs are synchronous already
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			irq_pin_reg <= 1'b1;
		end else begin
			irq_pin_reg <= irq_pin_n;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			key_reg <= '0;
		end else begin
			key_reg <= keypad_pins;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			xclk_reg <= 1'b0;
		end else begin
			xclk_reg <= crystal_ref_clock;
		end
	end

	// Pin history is unknown right after reset, so a pin resting at its
	// active level must not look like a fresh edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			edge_arm_reg <= 1'b0;
		end else begin
			edge_arm_reg <= 1'b1;
		end
	end

	assign irq_edge = edge_arm_reg && irq_pin_reg && !irq_pin_n;

	genvar k;
	generate
		for (k = 0; k < KEYS; k++) begin : g_key
			// Falling edge, or rising edge where polarity is set
			assign key_edge[k] = edge_arm_reg && keypad_enable[k] &&
				(keypad_edge_polarity[k] ?
				(!key_reg[k] && keypad_pins[k]) :
				(key_reg[k] && !keypad_pins[k]));
		end
	endgenerate

	assign key_any = |key_edge;
	// Crystal clock is sampled; its rising edges step the recovery count
	assign xclk_rise = !xclk_reg && crystal_ref_clock;

	always_comb begin
		req = periph_req;
		req.brk = break_req && emulation_mode;
		req.irq = irq_edge || periph_req.irq;
		req.keypad = key_any || periph_req.keypad;
		// Timebase only runs in stop while the oscillator is kept alive
		req.timebase = periph_req.timebase &&
			(!stop_mode_reg || osc_keep_in_stop);
	end

	wkr_vec_sel u_vec_sel (
		.req(req),
		.in_stop(stop_mode_reg),
		.hit(hit),
		.vec(sel_vec)
	);

	wkr_supply_mon u_supply_mon (
		.ref_clk(ref_clk),
		.rst(rst),
		.below_falling_trip(below_falling_trip),
		.above_rising_trip(above_rising_trip),
		.monitor_power_off(config_word_one.monitor_power_off),
		.monitor_reset_off(config_word_one.monitor_reset_off),
		.monitor_in_stop_en(config_word_one.monitor_in_stop_en),
		.in_stop(in_stop),
		.range_raised(range_raised),
		.supply_low_flag(supply_low_flag),
		.lv_reset(lv_reset)
	);

	// Power-on forces the range low; other resets keep it, otherwise it follows the select bit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			trip_high_reg <= 1'b0;
		end else if (power_on_reset) begin
			trip_high_reg <= 1'b0;
		end else begin
			trip_high_reg <= config_word_one.trip_range_high_sel;
		end
	end

	assign trip_range_high = trip_high_reg;

	// Raising the range while supply is under the new rising level trips
	// at once; power-on forces the range low instead
	assign range_raised = config_word_one.trip_range_high_sel &&
		!trip_high_reg && !power_on_reset;

	// Watchdog is live in run, wait and stop recovery; it is masked only while idle in stop
	assign dog_reset = watchdog_expire &&
		!(state_reg == wkr_pkg::WKR_IDLE && stop_mode_reg);
	assign pin_reset = !ext_reset_n;
	assign hard_reset = pin_reset || lv_reset || power_on_reset ||
		dog_reset;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_reg <= wkr_pkg::WKR_RUN;
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			wkr_pkg::WKR_RUN: begin
				if (wait_enter || stop_enter) begin
					state_next = wkr_pkg::WKR_IDLE;
				end
			end
			wkr_pkg::WKR_IDLE: begin
				if (hard_reset || hit) begin
					// Stop exit waits for the oscillator; wait exit does not
					state_next = stop_mode_reg ? wkr_pkg::WKR_RECOV :
						wkr_pkg::WKR_VECT;
				end
			end
			wkr_pkg::WKR_RECOV: begin
				if (recov_done && !hard_reset) begin
					state_next = wkr_pkg::WKR_VECT;
				end
			end
			wkr_pkg::WKR_VECT: begin
				if (!hard_reset) begin
					state_next = wkr_pkg::WKR_RUN;
				end
			end
			default: begin
				state_next = wkr_pkg::WKR_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stop_mode_reg <= 1'b0;
		end else if (state_reg == wkr_pkg::WKR_RUN) begin
			stop_mode_reg <= stop_enter;
		end
	end

	// Count crystal edges from the wake event; short select picks 32
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			recov_cnt_reg <= '0;
		end else if (state_reg != wkr_pkg::WKR_RECOV) begin
			recov_cnt_reg <= config_word_one.short_recovery_sel ?
				SHORT_COUNT : FULL_COUNT;
		end else if (xclk_rise && !recov_done) begin
			recov_cnt_reg <= recov_cnt_reg - 13'h0001;
		end
	end

	assign recov_done = recov_cnt_reg == 13'h0000;

	assign wake_take = state_reg == wkr_pkg::WKR_IDLE &&
		(hard_reset || hit);

	// Latch the vector of the waking event; reset wins over interrupts
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vec_hold_reg <= wkr_pkg::VEC_RESET;
		end else if (wake_take) begin
			vec_hold_reg <= hard_reset ? wkr_pkg::VEC_RESET : sel_vec;
		end else if (hard_reset) begin
			vec_hold_reg <= wkr_pkg::VEC_RESET;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vec_pend_reg <= 1'b0;
		end else if (wake_take) begin
			vec_pend_reg <= 1'b1;
		end else if (state_reg == wkr_pkg::WKR_VECT && !hard_reset) begin
			vec_pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vector_addr <= wkr_pkg::VEC_RESET;
		end else begin
			vector_addr <= vec_hold_reg;
		end
	end

	// One-cycle strobe; a reset in the same cycle holds it back
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			vector_valid <= 1'b0;
		end else begin
			vector_valid <= state_reg == wkr_pkg::WKR_VECT &&
				vec_pend_reg && !hard_reset;
		end
	end

	// Clocks off while idle and through recovery
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			clocks_run <= 1'b0;
		end else begin
			clocks_run <= state_next == wkr_pkg::WKR_RUN ||
				state_next == wkr_pkg::WKR_VECT;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			system_reset <= 1'b1;
		end else begin
			system_reset <= hard_reset;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reset_pin_drive_n <= 1'b1;
		end else begin
			reset_pin_drive_n <= !lv_reset;
		end
	end

	assign in_wait = state_reg != wkr_pkg::WKR_RUN && !stop_mode_reg;
	assign in_stop = state_reg != wkr_pkg::WKR_RUN && stop_mode_reg;
endmodule : wkr_wakeup_top

// ### hw/wkr_pkg.sv
// Package: constants and types for the wakeup recovery and low supply reset
package wkr_pkg;
	localparam logic [15:0] VEC_RESET = 16'hfffe;
	localparam logic [15:0] VEC_IRQ = 16'hfffa;
	localparam logic [15:0] VEC_BREAK = 16'hfffc;
	localparam logic [15:0] VEC_CLKGEN = 16'hfff8;
	localparam logic [15:0] VEC_T1_OVF = 16'hfff2;
	localparam logic [15:0] VEC_T1_CH1 = 16'hfff4;
	localparam logic [15:0] VEC_T1_CH0 = 16'hfff6;
	localparam logic [15:0] VEC_T2_OVF = 16'hffec;
	localparam logic [15:0] VEC_T2_CH1 = 16'hffee;
	localparam logic [15:0] VEC_T2_CH0 = 16'hfff0;
	localparam logic [15:0] VEC_T2_CH5 = 16'hffcc;
	localparam logic [15:0] VEC_T2_CH4 = 16'hffce;
	localparam logic [15:0] VEC_T2_CH3 = 16'hffd0;
	localparam logic [15:0] VEC_T2_CH2 = 16'hffd2;
	localparam logic [15:0] VEC_SYNC_TX = 16'hffe8;
	localparam logic [15:0] VEC_SYNC_RX = 16'hffea;
	localparam logic [15:0] VEC_ASYNC_TX = 16'hffe2;
	localparam logic [15:0] VEC_ASYNC_RX = 16'hffe4;
	localparam logic [15:0] VEC_ASYNC_ERR = 16'hffe6;
	localparam logic [15:0] VEC_KEYPAD = 16'hffe0;
	localparam logic [15:0] VEC_ADC = 16'hffde;
	localparam logic [15:0] VEC_TIMEBASE = 16'hffdc;
	localparam int RECOV_WIDTH = 12;
	localparam logic [12:0] RECOV_FULL = 13'h1000;
	localparam logic [12:0] RECOV_SHORT = 13'h0020;
	localparam int KEY_PINS = 8;

	typedef enum logic [1:0] {
		WKR_RUN = 2'b00,
		WKR_IDLE = 2'b01,
		WKR_RECOV = 2'b11,
		WKR_VECT = 2'b10
	} wkr_state_e;

	// Wakeup requests from peripherals, one bit per source
	typedef struct packed {
		logic brk;
		logic irq;
		logic keypad;
		logic timebase;
		logic clkgen;
		logic t1_ovf;
		logic t1_ch1;
		logic t1_ch0;
		logic [5:0] t2_ch;
		logic t2_ovf;
		logic sync_tx;
		logic sync_rx;
		logic async_tx;
		logic async_rx;
		logic async_err;
		logic adc;
	} wkr_req_s;

	typedef struct packed {
		logic monitor_power_off;
		logic monitor_reset_off;
		logic monitor_in_stop_en;
		logic trip_range_high_sel;
		logic short_recovery_sel;
	} wkr_cfg_s;
endpackage : wkr_pkg

// ### hw/wkr_vec_sel.sv
// Priority encoder picking the vector address of the highest wakeup source
`timescale 1ns/10ps
module wkr_vec_sel (
	input wire wkr_pkg::wkr_req_s req,
	input wire logic in_stop,
	output logic hit,
	output logic [15:0] vec
);
	// In stop only the stop-capable sources may wake
	always_comb begin
		hit = 1'b1;
		vec = wkr_pkg::VEC_RESET;
		if (req.brk) begin
			vec = wkr_pkg::VEC_BREAK;
		end else if (req.irq) begin
			vec = wkr_pkg::VEC_IRQ;
		end else if (req.keypad) begin
			vec = wkr_pkg::VEC_KEYPAD;
		end else if (req.timebase) begin
			vec = wkr_pkg::VEC_TIMEBASE;
		end else if (in_stop) begin
			hit = 1'b0;
		end else if (req.clkgen) begin
			vec = wkr_pkg::VEC_CLKGEN;
		end else if (req.t1_ovf) begin
			vec = wkr_pkg::VEC_T1_OVF;
		end else if (req.t1_ch1) begin
			vec = wkr_pkg::VEC_T1_CH1;
		end else if (req.t1_ch0) begin
			vec = wkr_pkg::VEC_T1_CH0;
		end else if (req.t2_ovf) begin
			vec = wkr_pkg::VEC_T2_OVF;
		end else if (req.t2_ch[1]) begin
			vec = wkr_pkg::VEC_T2_CH1;
		end else if (req.t2_ch[0]) begin
			vec = wkr_pkg::VEC_T2_CH0;
		end else if (req.sync_tx) begin
			vec = wkr_pkg::VEC_SYNC_TX;
		end else if (req.sync_rx) begin
			vec = wkr_pkg::VEC_SYNC_RX;
		end else if (req.async_tx) begin
			vec = wkr_pkg::VEC_ASYNC_TX;
		end else if (req.async_rx) begin
			vec = wkr_pkg::VEC_ASYNC_RX;
		end else if (req.async_err) begin
			vec = wkr_pkg::VEC_ASYNC_ERR;
		end else if (req.adc) begin
			vec = wkr_pkg::VEC_ADC;
		end else if (req.t2_ch[5]) begin
			vec = wkr_pkg::VEC_T2_CH5;
		end else if (req.t2_ch[4]) begin
			vec = wkr_pkg::VEC_T2_CH4;
		end else if (req.t2_ch[3]) begin
			vec = wkr_pkg::VEC_T2_CH3;
		end else if (req.t2_ch[2]) begin
			vec = wkr_pkg::VEC_T2_CH2;
		end else begin
			hit = 1'b0;
		end
	end
endmodule : wkr_vec_sel

// ### hw/wkr_supply_mon.sv
// Low supply monitor: flag with hysteresis and held reset request
`timescale 1ns/10ps
module wkr_supply_mon (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic below_falling_trip,
	input wire logic above_rising_trip,
	input wire logic monitor_power_off,
	input wire logic monitor_reset_off,
	input wire logic monitor_in_stop_en,
	input wire logic in_stop,
	input wire logic range_raised,
	output logic supply_low_flag,
	output logic lv_reset
);
	logic active;
	logic hold_reg;

	// Comparator is unpowered when disabled, or in stop without stop enable
	assign active = !monitor_power_off && (!in_stop || monitor_in_stop_en);

	// Flag sets below falling trip, clears above rising, holds between
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			supply_low_flag <= 1'b0;
		end else if (active && below_falling_trip) begin
			supply_low_flag <= 1'b1;
		end else if (active && above_rising_trip) begin
			supply_low_flag <= 1'b0;
		end
	end

	// Reset stays held until above rising trip; raising the range while
	// supply is not above the new rising level trips at once
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			hold_reg <= 1'b0;
		end else if (!active || monitor_reset_off) begin
			hold_reg <= 1'b0;
		end else if (below_falling_trip ||
			((hold_reg || range_raised) && !above_rising_trip)) begin
			hold_reg <= 1'b1;
		end else begin
			hold_reg <= 1'b0;
		end
	end

	assign lv_reset = hold_reg;
endmodule : wkr_supply_mon

// ### test/wkr_wakeup_top_assertions.sv
// Checker for the wakeup and low supply reset ports
`timescale 1ns/10ps
module wkr_wakeup_top_checker (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic power_on_reset,
	input wire logic ext_reset_n,
	input wire wkr_pkg::wkr_cfg_s config_word_one,
	input wire logic below_falling_trip,
	input wire logic above_rising_trip,
	input wire logic trip_range_high,
	input wire logic supply_low_flag,
	input wire logic system_reset,
	input wire logic reset_pin_drive_n,
	input wire logic clocks_run,
	input wire logic vector_valid,
	input wire logic [15:0] vector_addr,
	input wire logic in_stop
);
	logic act;
	logic rs_en;
	// Monitor is live when powered and, inside stop, only if kept on
	assign act = !config_word_one.monitor_power_off &&
		(!in_stop || config_word_one.monitor_in_stop_en);
	assign rs_en = act && !config_word_one.monitor_reset_off;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_vec_even: assert property (vector_valid |-> !vector_addr[0])
		else $error("odd vector address");
	a_valid_once: assert property (vector_valid |=> !vector_valid)
		else $error("vector strobe too long");
	a_stop_clk_off: assert property ($rose(in_stop) |-> !clocks_run)
		else $error("clocks run in stop");
	a_flag_set: assert property (act && below_falling_trip
		|-> ##[1:2] supply_low_flag) else $error("flag not set");
	a_flag_clear: assert property (act && above_rising_trip
		&& !below_falling_trip |-> ##[1:2] !supply_low_flag)
		else $error("flag not cleared");
	a_flag_hold: assert property ((act && !below_falling_trip
		&& !above_rising_trip)[*3] |-> $stable(supply_low_flag))
		else $error("flag moved between trips");
	a_low_reset: assert property (rs_en && below_falling_trip
		|-> ##[1:2] system_reset) else $error("no low supply reset");
	a_pin_low: assert property ($fell(reset_pin_drive_n)
		|-> ##[0:1] system_reset) else $error("pin low without reset");
	a_ext_reset: assert property (!ext_reset_n |-> ##[1:2] system_reset)
		else $error("reset pin ignored");
	a_por_range: assert property (power_on_reset
		|-> ##[1:2] !trip_range_high) else $error("range kept high");
	a_high_range: assert property (rs_en && trip_range_high
		&& !above_rising_trip |-> ##[1:2] system_reset)
		else $error("high range no reset");
	c_irq_vec: cover property (vector_valid && vector_addr == 16'hfffa);
	c_pin_low: cover property ($fell(reset_pin_drive_n));
	c_flag_up: cover property ($rose(supply_low_flag));
endmodule : wkr_wakeup_top_checker

bind wkr_wakeup_top wkr_wakeup_top_checker wkr_wakeup_top_checker_inst (
	.ref_clk, .rst, .power_on_reset, .ext_reset_n, .config_word_one,
	.below_falling_trip, .above_rising_trip, .trip_range_high,
	.supply_low_flag, .system_reset, .reset_pin_drive_n, .clocks_run,
	.vector_valid, .vector_addr, .in_stop
);

// ### test/wkr_periph_model.sv
// Peripheral request sources and crystal reference for the core side
`timescale 1ns/10ps
module wkr_periph_model (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [4:0] src,
	input wire logic fire,
	input wire logic vector_valid,
	output wkr_pkg::wkr_req_s periph_req,
	output logic crystal_ref_clock
);
	logic [20:0] req_reg;
	logic [1:0] div_reg;
	assign periph_req = req_reg;
	assign crystal_ref_clock = div_reg[1];
	// A source keeps asking until the core takes a vector, like a real flag
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			req_reg <= '0;
		else if (fire)
			req_reg <= 21'h1 << src;
		else if (vector_valid)
			req_reg <= '0;
	end
	// Crystal reference at a quarter of the core rate
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			div_reg <= '0;
		else
			div_reg <= div_reg + 2'h1;
	end
endmodule : wkr_periph_model

// ### test/wkr_wakeup_top_bench.sv
// Self-checking bench for the wakeup and low supply reset block
`timescale 1ns/10ps
module wkr_wakeup_top_bench;
	logic ref_clk = 1'b0;
	logic rst, power_on_reset, crystal_ref_clock, ext_reset_n, irq_pin_n;
	logic emulation_mode, break_req, watchdog_expire, osc_keep_in_stop;
	logic wait_enter, stop_enter, below_falling_trip, above_rising_trip;
	logic trip_range_high, supply_low_flag, system_reset, reset_pin_drive_n;
	logic clocks_run, vector_valid, in_wait, in_stop, fire;
	logic [15:0] vector_addr;
	logic [7:0] keypad_pins, keypad_edge_polarity, keypad_enable;
	logic [4:0] src;
	wkr_pkg::wkr_req_s periph_req;
	wkr_pkg::wkr_cfg_s config_word_one;
	int n_fail = 0;
	int samples_checked = 0;
	int n;
	// Expected vector per request bit, lowest bit first
	logic [15:0] vt [21] = '{16'hffde, 16'hffe6, 16'hffe4, 16'hffe2,
		16'hffea, 16'hffe8, 16'hffec, 16'hfff0, 16'hffee, 16'hffd2,
		16'hffd0, 16'hffce, 16'hffcc, 16'hfff6, 16'hfff4, 16'hfff2,
		16'hfff8, 16'hffdc, 16'hffe0, 16'hfffa, 16'hfffc};
	always #2 ref_clk = ~ref_clk;
	// Recovery counts cut down so stop exits stay short
	wkr_wakeup_top #(.FULL_COUNT(13'h0010), .SHORT_COUNT(13'h0004))
		wkr_wakeup_top_inst (.ref_clk, .rst, .power_on_reset,
		.crystal_ref_clock, .ext_reset_n, .irq_pin_n, .keypad_pins,
		.keypad_edge_polarity, .keypad_enable, .emulation_mode, .break_req,
		.watchdog_expire, .periph_req, .osc_keep_in_stop, .config_word_one,
		.wait_enter, .stop_enter, .below_falling_trip, .above_rising_trip,
		.trip_range_high, .supply_low_flag, .system_reset,
		.reset_pin_drive_n, .clocks_run, .vector_valid, .vector_addr,
		.in_wait, .in_stop);
	wkr_periph_model wkr_periph_model_inst (.ref_clk, .rst, .src, .fire,
		.vector_valid, .periph_req, .crystal_ref_clock);
	task automatic final_report;
		if (n_fail == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : final_report
	task automatic step(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : step
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic req(input int i);
		src = i[4:0];
		fire = 1'b1;
		step(1);
		fire = 1'b0;
	endtask : req
	task automatic wake(input logic [15:0] exp);
		n = 0;
		while (vector_valid !== 1'b1 && n < 300) begin
			step(1);
			n++;
		end
		chk({15'h0, vector_valid}, 16'h1);
		chk({15'h0, clocks_run}, 16'h1);
		chk(vector_addr, exp);
		step(2);
	endtask : wake
	task automatic enter(input logic s);
		wait_enter = !s;
		stop_enter = s;
		step(1);
		wait_enter = 1'b0;
		stop_enter = 1'b0;
		step(2);
		chk({13'h0, in_wait, in_stop, clocks_run}, {13'h0, !s, s, 1'b0});
	endtask : enter
	task automatic mon(input logic b, input logic a, input logic [15:0] e);
		below_falling_trip = b;
		above_rising_trip = a;
		step(3);
		chk({14'h0, system_reset, supply_low_flag}, e);
	endtask : mon
	initial begin
		rst = 1'b1;
		power_on_reset = 1'b0;
		ext_reset_n = 1'b1;
		irq_pin_n = 1'b1;
		config_word_one = '0;
		keypad_pins = 8'h00;
		keypad_edge_polarity = 8'h01;
		keypad_enable = 8'h01;
		emulation_mode = 1'b1;
		break_req = 1'b0;
		watchdog_expire = 1'b0;
		osc_keep_in_stop = 1'b0;
		wait_enter = 1'b0;
		stop_enter = 1'b0;
		below_falling_trip = 1'b0;
		above_rising_trip = 1'b1;
		src = 5'h00;
		fire = 1'b0;
		step(20);
		rst = 1'b0;
		step(2);
		chk({15'h0, system_reset}, 16'h0);
		for (int i = 0; i < 20; i++) begin
			enter(1'b0);
			req(i);
			wake(vt[i]);
		end
		// Break only counts through its own pin while emulating
		enter(1'b0);
		break_req = 1'b1;
		wake(vt[20]);
		break_req = 1'b0;
		enter(1'b1);
		irq_pin_n = 1'b0;
		wake(16'hfffa);
		chk({15'h0, n >= 60}, 16'h1);
		irq_pin_n = 1'b1;
		config_word_one.short_recovery_sel = 1'b1;
		enter(1'b1);
		keypad_pins = 8'h01;
		wake(16'hffe0);
		chk({14'h0, n > 12, n < 40}, 16'h3);
		keypad_pins = 8'h00;
		enter(1'b1);
		req(0);
		step(100);
		chk({15'h0, in_stop}, 16'h1);
		osc_keep_in_stop = 1'b1;
		req(17);
		wake(16'hffdc);
		enter(1'b1);
		mon(1'b1, 1'b0, 16'h0);
		config_word_one.monitor_in_stop_en = 1'b1;
		mon(1'b1, 1'b0, 16'h3);
		chk({15'h0, reset_pin_drive_n}, 16'h0);
		mon(1'b0, 1'b0, 16'h3);
		mon(1'b0, 1'b1, 16'h0);
		wake(16'hfffe);
		chk({14'h0, in_stop, reset_pin_drive_n}, 16'h1);
		config_word_one.monitor_reset_off = 1'b1;
		mon(1'b1, 1'b0, 16'h1);
		mon(1'b0, 1'b1, 16'h0);
		config_word_one.monitor_power_off = 1'b1;
		mon(1'b1, 1'b0, 16'h0);
		config_word_one = '0;
		config_word_one.trip_range_high_sel = 1'b1;
		mon(1'b0, 1'b0, 16'h2);
		chk({15'h0, trip_range_high}, 16'h1);
		power_on_reset = 1'b1;
		mon(1'b0, 1'b1, 16'h2);
		chk({15'h0, trip_range_high}, 16'h0);
		config_word_one.trip_range_high_sel = 1'b0;
		step(1);
		power_on_reset = 1'b0;
		mon(1'b0, 1'b1, 16'h0);
		enter(1'b0);
		watchdog_expire = 1'b1;
		step(2);
		chk({14'h0, system_reset, in_wait}, 16'h3);
		watchdog_expire = 1'b0;
		wake(16'hfffe);
		enter(1'b1);
		ext_reset_n = 1'b0;
		step(2);
		chk({14'h0, system_reset, in_stop}, 16'h3);
		ext_reset_n = 1'b1;
		wake(16'hfffe);
		final_report();
	end
	// Whole run needs several hundred cycles; this limit of 25000 cycles is far above it
	initial begin
		#100000;
		n_fail++;
		final_report();
	end
endmodule : wkr_wakeup_top_bench
